// *** src/amp_seq_pkg.sv ***
package amp_seq_pkg;
   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int MCLK_HZ = 24_576_000;
   localparam int HOLD_MS = 650;
   localparam int PROP_US = 200;
   // hold counted in master clock level changes, two per period
   localparam longint HOLD_CYC_L = longint'(HOLD_MS) * MCLK_HZ * 2 / 1000;
   localparam int HOLD_CYC = int'(HOLD_CYC_L);
   localparam int PROP_CYC = PROP_US * (CLK_HZ / 1_000_000);
   localparam int SOFT_CYC = 1024;
   localparam int MCLK_TIMEOUT_CYC = 64;
   localparam int WAIT_MS = 1000;
   localparam longint WAIT_CYC_L = longint'(WAIT_MS) * CLK_HZ / 1000;
   localparam int WAIT_CYC = int'(WAIT_CYC_L);

   // ***********************************************************
   // controller registers
   // ***********************************************************
   localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] STAT_OFS = 32'h0000_0004;
   localparam int CTRL_ON_BIT = 0;
   localparam int CTRL_AUTO_BIT = 1;
   localparam int CTRL_CLR_BIT = 2;
   localparam int STAT_FAULT_BIT = 0;
   localparam int STAT_WARN_BIT = 1;
   localparam int STAT_STBY_BIT = 2;
   localparam int STAT_MUTE_BIT = 3;
   localparam int STAT_BUSY_BIT = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_STANDBY, ST_HOLD, ST_PROP, ST_MUTED, ST_SOFT, ST_ACTIVE
   } amp_state_e;
   typedef enum logic [2:0] {
      C_OFF, C_WAIT, C_ON, C_CLR_LO, C_DOWN
   } ctl_state_e;
endpackage

// *** src/amp_link_if.sv ***
`timescale 1ns/1ns
interface amp_link_if;
   logic standby_n;
   logic mute_n_o;
   logic mute_n_oe_n;
   logic fault_n_o;
   logic fault_n_oe_n;
   logic thermal_warning_n_o;
   logic thermal_warning_n_oe_n;
   // wired levels with pull-ups; any enabled driver pulls low
   logic mute_n;
   logic fault_n;
   logic thermal_warning_n;
   assign fault_n = fault_n_oe_n ? 1'b1 : fault_n_o;
   assign thermal_warning_n = thermal_warning_n_oe_n ? 1'b1 : thermal_warning_n_o;
   assign mute_n = mute_n_oe_n ? 1'b1 : mute_n_o;
   modport device (
      input standby_n, mute_n,
      output fault_n_o, fault_n_oe_n, thermal_warning_n_o, thermal_warning_n_oe_n
   );
   modport ctrl (
      output standby_n, mute_n_o, mute_n_oe_n,
      input mute_n, fault_n, thermal_warning_n
   );
endinterface

// *** src/amp_protect.sv ***
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Function
// - overcurrent pulls fault low, latched
// - fault clears only on mute low-high
// - power supply low: hi-z, latched fault
// - master clock loss latches fault; here only while standby is high
// - warning low at band, release when cool
// - shutdown temperature latches same fault
// - one fault output for all causes
// - fault looped to mute gives auto restart
// - standby low: modulator off, stage hi-z
// - standby high: modulator runs, stage hi-z
// - mute high soft-starts, low disables stage
// - internal hold after standby overrides mute
// - switch after hold plus delay, mute high
// - controller waits longer than hold to unmute
// - either supply missing keeps stage off
// - controller mutes before standby on shutdown
// - supplies removed power, logic, analog order; here only the power stage supply is dropped
// - faults stop power stage at once
// - fault and warning outputs are open drain
// - warning alone keeps amplification running
module amp_protect #(
   parameter int HOLD_CYCLES = amp_seq_pkg::HOLD_CYC,
   parameter int PROP_CYCLES = amp_seq_pkg::PROP_CYC,
   parameter int SOFT_CYCLES = amp_seq_pkg::SOFT_CYC,
   parameter int MCLK_TIMEOUT = amp_seq_pkg::MCLK_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // sensed conditions, synchronous levels
   input wire logic over_current,
   input wire logic power_stage_supply_ok,
   input wire logic logic_supply_ok,
   input wire logic temp_warn,
   input wire logic temp_cool,
   input wire logic temp_shutdown,
   input wire logic mclk_in,
   // power stage
   output logic modulator_run,
   output logic stage_enable,
   output logic [7:0] soft_level,
   amp_link_if.device link
);
   import amp_seq_pkg::*;

   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      amp_state_e st;
      logic [31:0] cnt;
      logic [15:0] wd;
      logic mclk_d;
      logic fault;
      logic warn;
      logic mute_d;
      logic run;
      logic en;
      logic [7:0] lvl;
   } prot_s;

   prot_s s_reg;
   prot_s s_next;
   logic mute_rise;
   logic clk_lost;
   logic fault_evt;
   logic supplies_ok;

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      s_next = s_reg;
      supplies_ok = power_stage_supply_ok && logic_supply_ok;
      // ***********************************************************
      // edge detection and clock watchdog
      // ***********************************************************
      // mute edge register idles low like the pin during reset
      mute_rise = link.mute_n && !s_reg.mute_d;
      s_next.mute_d = link.mute_n;
      // watchdog restarts on every master clock edge
      s_next.mclk_d = mclk_in;
      if (mclk_in != s_reg.mclk_d) begin
         s_next.wd = '0;
      end else if (s_reg.wd < 16'(MCLK_TIMEOUT)) begin
         s_next.wd = s_reg.wd + 16'h1;
      end

      // ***********************************************************
      // protection latches
      // ***********************************************************
      clk_lost = (s_reg.wd >= 16'(MCLK_TIMEOUT)) && link.standby_n;
      fault_evt = over_current || !power_stage_supply_ok || !logic_supply_ok
                  || clk_lost || temp_shutdown;
      // set wins over the mute release
      if (fault_evt) begin
         s_next.fault = 1'b1;
      end else if (mute_rise) begin
         s_next.fault = 1'b0;
      end
      if (temp_warn) begin
         s_next.warn = 1'b1;
      end else if (temp_cool) begin
         s_next.warn = 1'b0;
      end

      // ***********************************************************
      // power sequence
      // ***********************************************************
      if (s_reg.cnt != '0) begin
         s_next.cnt = s_reg.cnt - 32'h1;
      end
      unique case (s_reg.st)
         ST_STANDBY: begin
            s_next.run = 1'b0;
            s_next.en = 1'b0;
            s_next.lvl = '0;
            if (link.standby_n) begin
               s_next.st = ST_HOLD;
               s_next.cnt = 32'(HOLD_CYCLES);
            end
         end
         ST_HOLD: begin
            s_next.run = 1'b1;
            // hold paced by master clock edges, stalls if that clock stops
            if (mclk_in == s_reg.mclk_d) begin
               s_next.cnt = s_reg.cnt;
            end
            if (s_reg.cnt == '0) begin
               s_next.st = ST_PROP;
               s_next.cnt = 32'(PROP_CYCLES);
            end
         end
         ST_PROP: begin
            if (s_reg.cnt == '0) begin
               s_next.st = ST_MUTED;
            end
         end
         ST_MUTED: begin
            s_next.en = 1'b0;
            s_next.lvl = '0;
            // unmute needs a clear latch and both supplies
            if (link.mute_n && !s_reg.fault && supplies_ok && !fault_evt) begin
               s_next.st = ST_SOFT;
               s_next.cnt = 32'(SOFT_CYCLES);
               s_next.en = 1'b1;
            end
         end
         ST_SOFT: begin
            // ramp from zero towards full scale
            s_next.lvl = 8'((32'(SOFT_CYCLES) - s_reg.cnt) * 255 / 32'(SOFT_CYCLES));
            if (s_reg.cnt == '0) begin
               s_next.st = ST_ACTIVE;
               s_next.lvl = 8'hff;
            end
         end
         ST_ACTIVE: begin
            // warning alone keeps playing
            s_next.lvl = 8'hff;
         end
         default: begin
            // unused codes fall back to the safe state
            s_next.st = ST_STANDBY;
            s_next.run = 1'b0;
            s_next.en = 1'b0;
            s_next.lvl = '0;
         end
      endcase
      if (s_reg.st == ST_SOFT || s_reg.st == ST_ACTIVE) begin
         if (!link.mute_n || fault_evt || s_reg.fault || !supplies_ok) begin
            s_next.st = ST_MUTED;
            s_next.en = 1'b0;
            s_next.lvl = '0;
         end
      end
      if (!link.standby_n) begin
         s_next.st = ST_STANDBY;
         s_next.run = 1'b0;
         s_next.en = 1'b0;
         s_next.lvl = '0;
         s_next.cnt = '0;
      end
   end

   // ***********************************************************
   // registers
   // ***********************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '{st: ST_STANDBY, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign modulator_run = s_reg.run;
   assign stage_enable = s_reg.en;
   assign soft_level = s_reg.lvl;
   // open drain: the pins are only ever pulled low
   assign link.fault_n_o = 1'b0;
   assign link.fault_n_oe_n = !s_reg.fault;
   assign link.thermal_warning_n_o = 1'b0;
   assign link.thermal_warning_n_oe_n = !s_reg.warn;
endmodule

// *** src/amp_ctrl.sv ***
`timescale 1ns/1ns
module amp_ctrl #(
   parameter int WAIT_CYCLES = amp_seq_pkg::WAIT_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // supply sequencing
   output logic power_stage_supply_off,
   amp_link_if.ctrl link
);
   import amp_seq_pkg::*;

   typedef struct packed {
      ctl_state_e st;
      logic [31:0] cnt;
      logic on;
      logic auto_rst;
      logic clr;
      logic stby;
      logic mute;
      logic wr_pend;
      logic [31:0] wr_addr;
      logic [31:0] rdata;
   } ctl_s;

   ctl_s s_reg;
   ctl_s s_next;
   logic take;

   always_comb begin
      s_next = s_reg;
      take = hsel && hready && htrans[1];
      s_next.wr_pend = take && hwrite;
      if (take) begin
         s_next.wr_addr = haddr;
      end
      if (take && !hwrite) begin
         s_next.rdata = '0;
         if (haddr[7:0] == CTRL_OFS[7:0]) begin
            s_next.rdata[CTRL_ON_BIT] = s_reg.on;
            s_next.rdata[CTRL_AUTO_BIT] = s_reg.auto_rst;
         end else if (haddr[7:0] == STAT_OFS[7:0]) begin
            s_next.rdata[STAT_FAULT_BIT] = !link.fault_n;
            s_next.rdata[STAT_WARN_BIT] = !link.thermal_warning_n;
            s_next.rdata[STAT_STBY_BIT] = !s_reg.stby;
            s_next.rdata[STAT_MUTE_BIT] = !s_reg.mute;
            s_next.rdata[STAT_BUSY_BIT] = (s_reg.st == C_WAIT) || (s_reg.st == C_CLR_LO);
         end
      end
      if (s_reg.wr_pend && s_reg.wr_addr[7:0] == CTRL_OFS[7:0]) begin
         s_next.on = hwdata[CTRL_ON_BIT];
         s_next.auto_rst = hwdata[CTRL_AUTO_BIT];
         s_next.clr = hwdata[CTRL_CLR_BIT];
      end
      if (s_reg.cnt != '0) begin
         s_next.cnt = s_reg.cnt - 32'h1;
      end
      unique case (s_reg.st)
         C_OFF: begin
            s_next.stby = 1'b0;
            s_next.mute = 1'b0;
            if (s_reg.on) begin
               s_next.st = C_WAIT;
               s_next.stby = 1'b1;
               s_next.cnt = 32'(WAIT_CYCLES);
            end
         end
         C_WAIT: begin
            if (!s_reg.on) begin
               s_next.st = C_DOWN;
            end else if (s_reg.cnt == '0) begin
               s_next.st = C_ON;
               s_next.mute = 1'b1;
            end
         end
         C_ON: begin
            if (!s_reg.on) begin
               s_next.mute = 1'b0;
               s_next.st = C_DOWN;
            end else if (!link.fault_n && (s_reg.auto_rst || s_reg.clr)) begin
               s_next.mute = 1'b0;
               s_next.clr = 1'b0;
               s_next.st = C_CLR_LO;
            end
         end
         C_CLR_LO: begin
            s_next.mute = 1'b1;
            s_next.st = C_ON;
         end
         C_DOWN: begin
            s_next.mute = 1'b0;
            s_next.stby = 1'b0;
            s_next.st = C_OFF;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '{st: C_OFF, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign hrdata = s_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // power stage supply dropped first once muted and in standby
   assign power_stage_supply_off = (s_reg.st == C_OFF);
   assign link.standby_n = s_reg.stby;
   assign link.mute_n_o = 1'b0;
   assign link.mute_n_oe_n = s_reg.mute;
endmodule

// *** verif/amp_link_checker.sv ***
`timescale 1ns/1ns
// *****
// link checks
// *****
module amp_link_checker #(
   parameter int WAIT_CYCLES = amp_seq_pkg::WAIT_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // link wires
   input wire logic standby_n,
   input wire logic mute_n,
   input wire logic fault_n,
   input wire logic fault_n_o,
   input wire logic fault_n_oe_n,
   input wire logic thermal_warning_n_o,
   input wire logic thermal_warning_n_oe_n
);
   int cnt_reg;
   // cycles since standby went high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= 0;
      end else begin
         cnt_reg <= standby_n ? cnt_reg + 1 : 0;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence mute_rise_s;
      !mute_n ##1 mute_n;
   endsequence
   AST_FAULT_HOLD: assert property (!fault_n && !$rose(mute_n) |=> !fault_n)
      else $error("fault released without mute toggle");
   AST_FAULT_CLEAR: assert property ($rose(fault_n) |-> $past(mute_n) && !$past(mute_n, 2))
      else $error("fault cleared without mute rise");
   AST_FAULT_OD: assert property (!fault_n_oe_n |-> !fault_n_o)
      else $error("fault pin driven high");
   AST_WARN_OD: assert property (!thermal_warning_n_oe_n |-> !thermal_warning_n_o)
      else $error("warning pin driven high");
   AST_MUTE_FIRST: assert property ($fell(standby_n) |-> !$past(mute_n))
      else $error("standby dropped while unmuted");
   AST_UNMUTE_WAIT: assert property (mute_rise_s |-> !standby_n || cnt_reg > WAIT_CYCLES)
      else $error("unmute too soon after standby");
   COV_FAULT: cover property ($fell(fault_n));
endmodule

// *** verif/test_amp_fault_latch_power_sequencer.sv ***
`timescale 1ns/1ns
module test_amp_fault_latch_power_sequencer;
   import amp_seq_pkg::*;
   // *****
   // bench
   // *****
   localparam int WAITC = 20;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, psu_off, mclk_run;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic over_current, pss_ok, lgs_ok, temp_warn, temp_cool, temp_shutdown, mclk_in;
   logic modulator_run, stage_enable;
   logic [7:0] soft_level;
   int fails, comparisons, n;
   amp_link_if link ();
   amp_protect #(.HOLD_CYCLES(10), .PROP_CYCLES(3), .SOFT_CYCLES(8)) i_amp_protect (
      .hclk(hclk), .hresetn(hresetn), .over_current(over_current),
      .power_stage_supply_ok(pss_ok), .logic_supply_ok(lgs_ok), .temp_warn(temp_warn),
      .temp_cool(temp_cool), .temp_shutdown(temp_shutdown), .mclk_in(mclk_in),
      .modulator_run(modulator_run), .stage_enable(stage_enable), .soft_level(soft_level),
      .link(link));
   amp_ctrl #(.WAIT_CYCLES(WAITC)) i_amp_ctrl (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .power_stage_supply_off(psu_off), .link(link));
   amp_link_checker #(.WAIT_CYCLES(WAITC)) i_amp_link_checker (
      .hclk(hclk), .hresetn(hresetn), .standby_n(link.standby_n), .mute_n(link.mute_n),
      .fault_n(link.fault_n), .fault_n_o(link.fault_n_o), .fault_n_oe_n(link.fault_n_oe_n),
      .thermal_warning_n_o(link.thermal_warning_n_o),
      .thermal_warning_n_oe_n(link.thermal_warning_n_oe_n));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (mclk_run) begin
         mclk_in <= ~mclk_in;
      end
   end
   task print_verdict;
      $display("counts: fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      chk(hresp, 1'b0, "error response");
      if (n >= 100) begin
         fails++;
         $display("mismatch at %0t: bus wait timed out", $time);
         print_verdict;
      end
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return stage_enable;
         1: return link.fault_n;
         2: return link.standby_n;
         default: return soft_level == 8'hff;
      endcase
   endfunction
   task wait_for(input int w, input logic want);
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (pick(w) !== want && n < 300);
      if (n >= 300) begin
         fails++;
         $display("mismatch at %0t: wait %0d timed out", $time, w);
         print_verdict;
      end
   endtask
   task set_cause(input int c, input logic v);
      @(posedge hclk);
      case (c)
         0: over_current <= v;
         1: pss_ok <= ~v;
         2: temp_shutdown <= v;
         3: mclk_run <= ~v;
         default: lgs_ok <= ~v;
      endcase
   endtask
   task s_power_up;
      ahb(1'b0, CTRL_OFS, 0);
      chk(rd, CTRL_RESET, "ctrl reset value");
      ahb(1'b0, 32'h40, 0);
      chk(rd, 0, "unmapped read");
      ahb(1'b1, CTRL_OFS, 32'h1);
      ahb(1'b0, STAT_OFS, 0);
      chk(rd, (32'h1 << STAT_MUTE_BIT) | (32'h1 << STAT_BUSY_BIT), "status waiting");
      repeat (10) @(negedge hclk);
      chk(modulator_run, 1, "modulator idle");
      chk(stage_enable, 0, "stage on during hold");
      wait_for(0, 1'b1);
      chk(soft_level == 8'hff, 0, "no soft start");
      wait_for(3, 1'b1);
   endtask
   task s_warn;
      temp_cool <= 1'b0;
      set_cause(9, 1'b0);
      temp_warn <= 1'b1;
      repeat (3) @(negedge hclk);
      chk(link.thermal_warning_n, 0, "no warning");
      chk(stage_enable, 1, "stage stopped on warning");
      ahb(1'b0, STAT_OFS, 0);
      chk(rd, 32'h1 << STAT_WARN_BIT, "status warning bit");
      set_cause(9, 1'b0);
      temp_warn <= 1'b0;
      repeat (3) @(negedge hclk);
      chk(link.thermal_warning_n, 0, "warning released hot");
      set_cause(9, 1'b0);
      temp_cool <= 1'b1;
      repeat (3) @(negedge hclk);
      chk(link.thermal_warning_n, 1, "warning stuck");
   endtask
   task s_faults;
      for (int c = 0; c < 5; c++) begin
         set_cause(c, 1'b1);
         repeat (c == 3 ? 80 : 3) @(negedge hclk);
         chk(stage_enable, 0, "stage on in fault");
         set_cause(c, 1'b0);
         repeat (5) @(negedge hclk);
         chk(link.fault_n, 0, "fault not latched");
         ahb(1'b0, STAT_OFS, 0);
         chk(rd[STAT_FAULT_BIT], 1, "status fault bit");
         ahb(1'b1, CTRL_OFS, 32'h5);
         wait_for(1, 1'b1);
         wait_for(0, 1'b1);
      end
   endtask
   task s_auto_down;
      ahb(1'b1, CTRL_OFS, 32'h3);
      ahb(1'b0, CTRL_OFS, 0);
      chk(rd, (32'h1 << CTRL_ON_BIT) | (32'h1 << CTRL_AUTO_BIT), "control readback");
      set_cause(0, 1'b1);
      set_cause(0, 1'b0);
      wait_for(1, 1'b0);
      wait_for(1, 1'b1);
      wait_for(0, 1'b1);
      ahb(1'b1, CTRL_OFS, 0);
      wait_for(2, 1'b0);
      chk(link.mute_n, 0, "mute high in standby");
      repeat (3) @(negedge hclk);
      chk(modulator_run, 0, "modulator on in standby");
      chk(stage_enable, 0, "stage on in standby");
      chk(psu_off, 1, "power supply kept on");
   endtask
   initial begin
      {hresetn, hsel, hwrite, over_current, temp_warn, temp_shutdown, mclk_in} = '0;
      {pss_ok, lgs_ok, temp_cool, mclk_run} = '1;
      {htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      fails = 0;
      comparisons = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      s_power_up;
      s_warn;
      s_faults;
      s_auto_down;
      print_verdict;
   end
endmodule
